// ---- sim/mcu_parallel_ports_strobes_bench.sv ----
/*
 * Self-checking bench for the port unit in modes 7 and 5.
 * Assumes mpps_periph as the far side and an AXI4-Lite master made here.
 */
module mcu_parallel_ports_strobes_bench
	import mpps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic arst_n = 1'b1;
	logic [7:0] s_awaddr, s_araddr, port1In, port3In, port4In, extRdata, ext1, ext3, ext4;
	logic [31:0] s_wdata, s_rdata, d;
	logic [3:0] s_wstrb;
	logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready;
	logic s_bvalid, s_arready, s_rvalid, compareOut, busClockE, maskableIrqLineOneN;
	logic [1:0] s_bresp, s_rresp, r;
	mpps_busreq_s busReq;
	logic [4:0] port2In, port2Out, port2Oe, ext2;
	mpps_pin_s port1Drive, port3Drive, port4Drive, drv;
	logic strobeLineOneIn, strobeLineOneOut, strobeLineOneOe, strobeLineTwo, fireStrobe;
	// Reference state: direction and value per port, plus event counters.
	int fail_count, compares, cyc, pulses, n0, e;
	int dirM[4], valM[4];
	logic [3:0] dirIdx[4] = '{IDX_P1_DIR, IDX_P2_DIR, IDX_P3_DIR, IDX_P4_DIR};
	logic [3:0] valIdx[4] = '{IDX_P1_VAL, IDX_P2_VAL, IDX_P3_VAL, IDX_P4_VAL};

	mpps_ports u_mpps_ports (.mclk(mclk), .arst_n(arst_n), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.busReq(busReq), .extRdata(extRdata), .compareOut(compareOut), .busClockE(busClockE),
		.maskableIrqLineOneN(maskableIrqLineOneN), .port1In(port1In), .port1Drive(port1Drive),
		.port2In(port2In), .port2Out(port2Out), .port2Oe(port2Oe), .port3In(port3In),
		.port3Drive(port3Drive), .port4In(port4In), .port4Drive(port4Drive),
		.strobeLineOneIn(strobeLineOneIn), .strobeLineOneOut(strobeLineOneOut),
		.strobeLineOneOe(strobeLineOneOe), .strobeLineTwo(strobeLineTwo));
	mpps_periph u_mpps_periph (.mclk(mclk), .port1Drive(port1Drive), .port2Out(port2Out),
		.port2Oe(port2Oe), .port3Drive(port3Drive), .port4Drive(port4Drive), .ext1(ext1),
		.ext2(ext2), .ext3(ext3), .ext4(ext4), .fireStrobe(fireStrobe), .port1In(port1In),
		.port2In(port2In), .port3In(port3In), .port4In(port4In),
		.strobeLineOneIn(strobeLineOneIn));

	always #50 mclk = ~mclk;
	// Counts output strobe pulses once reset is over.
	always @(negedge strobeLineTwo) begin
		if (arst_n) pulses++;
	end
	// Hang guard; the full run needs well under two thousand cycles.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end

	function automatic logic [7:0] ba(input logic [3:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ba

	task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkData

	task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: resp %h expected %h", $time, got, exp);
		end
	endtask : chkResp

	// Ready is registered, so the level at the falling edge is what the next rise takes.
	task automatic axWrite(input logic [7:0] a, input logic [7:0] v);
		logic aw, w, b;
		@(posedge mclk);
		s_awaddr <= a;
		s_wdata <= {24'h0, v};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(negedge mclk);
			aw = s_awvalid && s_awready;
			w = s_wvalid && s_wready;
			b = s_bvalid;
			r = s_bresp;
			@(posedge mclk);
			if (aw) s_awvalid <= 1'b0;
			if (w) s_wvalid <= 1'b0;
		end while (!b);
		s_bready <= 1'b0;
	endtask : axWrite

	task automatic axRead(input logic [7:0] a);
		logic ar, rv;
		@(posedge mclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(negedge mclk);
			ar = s_arvalid && s_arready;
			rv = s_rvalid;
			d = s_rdata;
			r = s_rresp;
			@(posedge mclk);
			if (ar) s_arvalid <= 1'b0;
		end while (!rv);
		s_rready <= 1'b0;
	endtask : axRead

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		axRead(a);
		chkData(d & m, exp & m);
	endtask : rdChk

	// Pulses the far side's strobe request for one cycle, then lets it settle.
	task automatic strobe();
		@(posedge mclk);
		fireStrobe <= 1'b1;
		@(posedge mclk);
		fireStrobe <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask : strobe

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	initial begin
		{s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{busReq, compareOut, ext1, ext3, ext4, fireStrobe} = '0;
		s_wstrb = 4'h1;
		arst_n <= 1'b0;
		ext2 = 5'h07;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		void'($urandom(14));
		// Mode pins were high at release, so mode 7 reads back on top.
		rdChk(ba(IDX_P2_VAL), {24'h0, 3'h7, ext2}, 32'hFF);
		rdChk(ba(IDX_P1_DIR), 32'h0, 32'hFFFFFFFF);
		// Random direction, value and far-side level on every port.
		for (int p = 0; p < 4; p++) begin
			dirM[p] = $urandom & 8'hFF;
			valM[p] = $urandom & 8'hFF;
			e = $urandom & 8'hFF;
			compareOut <= 1'($urandom);
			if (p == 1) dirM[p] = (dirM[p] & 8'h1F) | 8'h02;
			case (p)
				0: ext1 <= e[7:0];
				1: ext2 <= e[4:0];
				2: ext3 <= e[7:0];
				default: ext4 <= e[7:0];
			endcase
			axWrite(ba(dirIdx[p]), dirM[p][7:0]);
			axWrite(ba(valIdx[p]), valM[p][7:0]);
			chkResp(r, RESP_OKAY);
			repeat (2) @(posedge mclk);
			e = (valM[p] & dirM[p]) | (e & ~dirM[p]);
			if (p == 1) begin
				// Line 1 carries the compare output, so its data bit is left out.
				rdChk(ba(valIdx[p]), {24'h0, 3'h7, e[4:0]}, 32'hFD);
				chkData({27'h0, port2Oe}, dirM[p]);
				chkData({31'h0, port2Out[1]}, {31'h0, compareOut});
			end else begin
				rdChk(ba(valIdx[p]), e, 32'hFF);
				drv = (p == 0) ? port1Drive : (p == 2) ? port3Drive : port4Drive;
				chkData({24'h0, drv.oe}, dirM[p]);
				chkData({24'h0, drv.out & drv.oe}, valM[p] & dirM[p]);
			end
		end
		// Unmapped places refuse both reads and writes.
		rdChk(8'h20, 32'h0, 32'hFFFFFFFF);
		chkResp(r, RESP_SLVERR);
		axWrite(8'h24, 8'hFF);
		chkResp(r, RESP_SLVERR);
		// Latch and interrupt on, port three as inputs.
		axWrite(ba(IDX_P3_DIR), 8'h00);
		axWrite(ba(IDX_P3_CSR), 8'h48);
		e = $urandom & 8'hFF;
		ext3 <= e[7:0];
		strobe();
		ext3 <= ~e[7:0];
		repeat (2) @(posedge mclk);
		chkData({31'h0, maskableIrqLineOneN}, 32'h0);
		n0 = pulses;
		rdChk(ba(IDX_P3_CSR), 32'hC8, 32'hD8);
		rdChk(ba(IDX_P3_VAL), e, 32'hFF);
		rdChk(ba(IDX_P3_CSR), 32'h48, 32'hD8);
		chkData({31'h0, maskableIrqLineOneN}, 32'h1);
		rdChk(ba(IDX_P3_VAL), ~e, 32'hFF);
		chkData(pulses, n0 + 2);
		// Strobe on writes, interrupt disabled.
		axWrite(ba(IDX_P3_CSR), 8'h10);
		n0 = pulses;
		axWrite(ba(IDX_P3_VAL), 8'h5A);
		axRead(ba(IDX_P3_VAL));
		chkData(pulses, n0 + 1);
		strobe();
		chkData({31'h0, maskableIrqLineOneN}, 32'h1);
		rdChk(ba(IDX_P3_CSR), 32'h90, 32'hD8);
		// Reset again with mode 5 pins: the non-multiplexed bus takes over.
		arst_n <= 1'b0;
		ext2 <= 5'h05;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		busReq <= {2'b11, IO_WIN_LO | 16'h0033, 8'h00};
		axWrite(ba(IDX_P4_DIR), 8'hFF);
		repeat (4) @(posedge mclk);
		chkData({29'h0, strobeLineOneOe, strobeLineOneOut, strobeLineTwo}, 32'h5);
		chkData({24'h0, extRdata}, {24'h0, ~e[7:0]});
		chkData({16'h0, port4Drive}, 32'h33FF);
		final_report();
	end
endmodule : mcu_parallel_ports_strobes_bench

// ---- sim/mpps_periph.sv ----
/*
 * Peripheral on the far side of the ports: drives every line the unit leaves
 * undriven and makes the input strobe. Assumes mclk timing for all pins.
 */
module mpps_periph
	import mpps_pkg::*;
#(
	parameter int LOW_CYCLES = 3
)
(
	input wire logic mclk,
	input wire mpps_pin_s port1Drive,
	input wire logic [4:0] port2Out,
	input wire logic [4:0] port2Oe,
	input wire mpps_pin_s port3Drive,
	input wire mpps_pin_s port4Drive,
	input wire logic [7:0] ext1,
	input wire logic [4:0] ext2,
	input wire logic [7:0] ext3,
	input wire logic [7:0] ext4,
	input wire logic fireStrobe,
	output logic [7:0] port1In,
	output logic [4:0] port2In,
	output logic [7:0] port3In,
	output logic [7:0] port4In,
	output logic strobeLineOneIn
);
	timeunit 1ns;
	timeprecision 1ns;
	// Cycles left in the current low strobe pulse.
	int lowLeft = 0;

	// Each wire shows the unit's level where it drives, else ours.
	assign port1In = (port1Drive.out & port1Drive.oe) | (ext1 & ~port1Drive.oe);
	assign port2In = (port2Out & port2Oe) | (ext2 & ~port2Oe);
	assign port3In = (port3Drive.out & port3Drive.oe) | (ext3 & ~port3Drive.oe);
	assign port4In = (port4Drive.out & port4Drive.oe) | (ext4 & ~port4Drive.oe);

	// A request starts one low pulse; the strobe idles high.
	always @(posedge mclk) begin
		if (fireStrobe && lowLeft == 0) begin
			lowLeft <= LOW_CYCLES;
		end else if (lowLeft > 0) begin
			lowLeft <= lowLeft - 1;
		end
	end
	assign strobeLineOneIn = (lowLeft == 0);
endmodule : mpps_periph

// ---- sim/mpps_ports_chk.sv ----
/*
 * Concurrent checks on the parallel port unit, seen from its ports only.
 * Assumes a bind onto mpps_ports and a single mclk domain with arst_n.
 */
module mpps_ports_chk
	import mpps_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [1:0] s_bresp,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire mpps_pin_s port1Drive,
	input wire logic [4:0] port2Oe,
	input wire logic strobeLineOneOe,
	input wire logic strobeLineTwo,
	input wire logic busClockE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// High when a read address falls outside the decoded register set.
	logic unmapped;
	assign unmapped = (s_araddr[7:6] != 2'h0) || (s_araddr[5:2] > 4'h7 && s_araddr[5:2] != 4'hF);

	property p_rHold;
		s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read data dropped early");
	property p_bHold;
		s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("write response dropped early");
	// Unmapped reads answer with an error and zero data.
	property p_slvErr;
		s_arvalid && s_arready && unmapped |=> s_rvalid && s_rresp == RESP_SLVERR && s_rdata == 32'h0;
	endproperty
	a_slvErr: assert property (p_slvErr) else $error("unmapped read not refused");
	property p_wrSeq;
		s_awvalid && s_awready && s_wvalid && s_wready |=> !s_awready ##1 s_bvalid;
	endproperty
	a_wrSeq: assert property (p_wrSeq) else $error("write response late");
	property p_upperZero;
		s_rvalid |-> s_rdata[31:8] == 24'h0;
	endproperty
	a_upperZero: assert property (p_upperZero) else $error("upper read lanes set");
	// Reset must hold the port one and two lines as inputs, so this one ignores the disable.
	property p_rstIn;
		disable iff (1'b0) !arst_n |-> port1Drive.oe == 8'h00 && port2Oe == 5'h00;
	endproperty
	a_rstIn: assert property (p_rstIn) else $error("line driven in reset");
	// In single chip the output strobe is a pulse of one cycle.
	property p_os3;
		!strobeLineOneOe && $fell(strobeLineTwo) |=> strobeLineTwo;
	endproperty
	a_os3: assert property (p_os3) else $error("output strobe too long");
	property p_oeCause;
		$changed(port1Drive.oe) |-> $past(s_bvalid);
	endproperty
	a_oeCause: assert property (p_oeCause) else $error("direction moved unasked");
	property p_eDuty;
		$rose(busClockE) |=> busClockE ##1 !busClockE [*2] ##1 busClockE;
	endproperty
	a_eDuty: assert property (p_eDuty) else $error("bus clock duty wrong");
	c_os3: cover property ($fell(strobeLineTwo));
	c_err: cover property (s_rvalid && s_rresp == RESP_SLVERR);
	c_oe: cover property ($changed(port1Drive.oe));
endmodule : mpps_ports_chk

bind mpps_ports mpps_ports_chk u_mpps_ports_chk (.mclk(mclk), .arst_n(arst_n),
	.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp), .s_araddr(s_araddr),
	.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
	.s_rvalid(s_rvalid), .s_rready(s_rready), .port1Drive(port1Drive), .port2Oe(port2Oe),
	.strobeLineOneOe(strobeLineOneOe), .strobeLineTwo(strobeLineTwo), .busClockE(busClockE));

// ---- verilog/mpps_pkg.sv ----
/*
 * Shared constants and types for the parallel port and strobe unit.
 * Assumes a 32-bit AXI4-Lite register bus where each register takes one aligned word.
 */
package mpps_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [3:0] IDX_P1_DIR = 4'h0;
	localparam logic [3:0] IDX_P2_DIR = 4'h1;
	localparam logic [3:0] IDX_P1_VAL = 4'h2;
	localparam logic [3:0] IDX_P2_VAL = 4'h3;
	localparam logic [3:0] IDX_P3_DIR = 4'h4;
	localparam logic [3:0] IDX_P4_DIR = 4'h5;
	localparam logic [3:0] IDX_P3_VAL = 4'h6;
	localparam logic [3:0] IDX_P4_VAL = 4'h7;
	localparam logic [3:0] IDX_P3_CSR = 4'hF;

	// Control/status field positions of the port three strobe register.
	localparam int CSR_LATCH_BIT = 3;
	localparam int CSR_SRCSEL_BIT = 4;
	localparam int CSR_IEN_BIT = 6;
	localparam int CSR_FLAG_BIT = 7;

	// Port two data register bit that moves test mode 4 to mode 5.
	localparam int P2_MODE_SWITCH_BIT = 5;

	// Reset values.
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [2:0] MODE_RESET = 3'h7;

	// Operating mode codes that matter to this unit.
	localparam logic [2:0] MODE_SC_TEST = 3'h4;
	localparam logic [2:0] MODE_NMUX = 3'h5;
	localparam logic [2:0] MODE_MUX_PARTIAL = 3'h6;
	localparam logic [2:0] MODE_SC = 3'h7;

	// External I/O window decoded in non-multiplexed mode.
	localparam logic [15:0] IO_WIN_LO = 16'h0100;
	localparam logic [15:0] IO_WIN_HI = 16'h01FF;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Fundamental bus type derived from the mode code.
	typedef enum logic [1:0] {
		BUS_SINGLE = 2'b00,
		BUS_NMUX = 2'b01,
		BUS_MUX = 2'b10
	} mpps_bus_e;

	// Quarter phases of one E cycle; E is high in the two data phases.
	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_TURN = 2'b01,
		PH_DATA0 = 2'b10,
		PH_DATA1 = 2'b11
	} mpps_phase_e;

	// One external bus request from the processor core.
	typedef struct packed {
		logic req;
		logic rw;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mpps_busreq_s;

	// Drive of one port: level and output enable per line.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} mpps_pin_s;

endpackage : mpps_pkg

// ---- verilog/mpps_ports.sv ----
/*
 * Parallel port unit: four ports, their direction registers, the port three
 * strobe control register and the two mode-dependent strobe lines.
 * Assumes pin inputs synchronous to mclk, an AXI4-Lite master, and a core
 * that presents one external bus request per E cycle, held for the cycle.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
module mpps_ports
	import mpps_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	// AXI4-Lite slave.
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Core side.
	input wire mpps_busreq_s busReq,
	output logic [7:0] extRdata,
	input wire logic compareOut,
	output logic busClockE,
	output logic maskableIrqLineOneN,
	// Pins.
	input wire logic [7:0] port1In,
	output mpps_pin_s port1Drive,
	input wire logic [4:0] port2In,
	output logic [4:0] port2Out,
	output logic [4:0] port2Oe,
	input wire logic [7:0] port3In,
	output mpps_pin_s port3Drive,
	input wire logic [7:0] port4In,
	output mpps_pin_s port4Drive,
	input wire logic strobeLineOneIn,
	output logic strobeLineOneOut,
	output logic strobeLineOneOe,
	output logic strobeLineTwo
);

	// Direction registers, all inputs after reset.
	logic [7:0] p1Dir_ff;
	logic [4:0] p2Dir_ff;
	logic [7:0] p3Dir_ff;
	logic [7:0] p4Dir_ff;
	// Stored output data.
	logic [7:0] p1Data_ff;
	logic [4:0] p2Data_ff;
	logic [7:0] p3Data_ff;
	logic [7:0] p4Data_ff;
	// Mode code and the flag that it has been taken after reset.
	logic [2:0] mode_ff;
	logic modeTaken_ff;
	// Strobe control fields.
	logic latchEn_ff;
	logic srcSel_ff;
	logic irqEn_ff;
	logic strobeFlag_ff;
	logic clearArmed_ff;
	logic [7:0] p3Latch_ff;
	logic p3Held_ff;
	logic strobePrev_ff;
	// E phase counter.
	mpps_phase_e phase_ff;
	// AXI state.
	logic awHeld_ff;
	logic wHeld_ff;
	logic [3:0] awIdx_ff;
	logic awBad_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	// Output flops.
	logic awReady_ff, wReady_ff, bValid_ff, arReady_ff, rValid_ff;
	logic [1:0] bResp_ff, rResp_ff;
	logic [31:0] rData_ff;
	logic [7:0] extRdata_ff;
	logic eClk_ff, irqN_ff;
	mpps_pin_s p1Drive_ff, p3Drive_ff, p4Drive_ff;
	logic [4:0] p2Out_ff, p2Oe_ff;
	logic s1Out_ff, s1Oe_ff, s2_ff;

	// Decoded bus type and access strobes.
	mpps_bus_e busType;
	logic single;
	logic wrFire, rdFire, wrLane;
	logic nxt_awHeld, nxt_wHeld, nxt_bValid, nxt_rValid;
	logic p3DataRead, p3DataWrite, csrRead, strobeFall;
	logic [7:0] p1Read, p3Read, p4Read, p3InSel;
	logic [4:0] p2Read;
	logic [7:0] rdByte;
	logic rdBad;
	logic ioWin;

	// Mode grouping: 4 and 7 single chip, 5 non-mux, the rest mux.
	always_comb begin
		case (mode_ff)
			MODE_SC_TEST, MODE_SC: busType = BUS_SINGLE;
			MODE_NMUX: busType = BUS_NMUX;
			default: busType = BUS_MUX;
		endcase
	end
	assign single = (busType == BUS_SINGLE);

	// Write path: address and data taken in either order, response after both.
	always_comb begin
		wrFire = awHeld_ff & wHeld_ff & ~bValid_ff;
		nxt_awHeld = wrFire ? 1'b0 : (awHeld_ff | (s_awvalid & awReady_ff));
		nxt_wHeld = wrFire ? 1'b0 : (wHeld_ff | (s_wvalid & wReady_ff));
		nxt_bValid = wrFire | (bValid_ff & ~s_bready);
		rdFire = s_arvalid & arReady_ff;
		nxt_rValid = rdFire | (rValid_ff & ~s_rready);
	end
	assign wrLane = wrFire & wStrb_ff[0] & ~awBad_ff;

	// AXI handshake flops; ready flops fall while a transfer is pending.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			bValid_ff <= 1'b0;
			rValid_ff <= 1'b0;
			awReady_ff <= 1'b0;
			wReady_ff <= 1'b0;
			arReady_ff <= 1'b0;
		end else begin
			awHeld_ff <= nxt_awHeld;
			wHeld_ff <= nxt_wHeld;
			bValid_ff <= nxt_bValid;
			rValid_ff <= nxt_rValid;
			awReady_ff <= ~nxt_awHeld & ~nxt_bValid;
			wReady_ff <= ~nxt_wHeld & ~nxt_bValid;
			arReady_ff <= ~nxt_rValid;
		end
	end

	// Captured write address and data, plus the write response code.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awIdx_ff <= 4'h0;
			awBad_ff <= 1'b0;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
			bResp_ff <= RESP_OKAY;
		end else begin
			if (s_awvalid && awReady_ff) begin
				awIdx_ff <= s_awaddr[5:2];
				// Anything past the last index or not decoded is refused.
				awBad_ff <= (s_awaddr[7:6] != 2'b00) ||
					((s_awaddr[5:2] > IDX_P4_VAL) && (s_awaddr[5:2] != IDX_P3_CSR));
			end
			if (s_wvalid && wReady_ff) begin
				wData_ff <= s_wdata;
				wStrb_ff <= s_wstrb;
			end
			if (wrFire) begin
				bResp_ff <= awBad_ff ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// Pin read values: stored bit for outputs, pin for inputs, except held port three inputs read the latch.
	always_comb begin
		p3InSel = (p3Held_ff && latchEn_ff && single) ? p3Latch_ff : port3In;
		p1Read = (p1Dir_ff & p1Data_ff) | (~p1Dir_ff & port1In);
		p2Read = (p2Dir_ff & p2Data_ff) | (~p2Dir_ff & port2In);
		p3Read = (p3Dir_ff & p3Data_ff) | (~p3Dir_ff & p3InSel);
		p4Read = (p4Dir_ff & p4Data_ff) | (~p4Dir_ff & port4In);
	end

	// Read decode; direction registers give zero since they cannot be read back.
	always_comb begin
		rdByte = 8'h00;
		rdBad = 1'b0;
		if (s_araddr[7:6] != 2'b00) begin
			rdBad = 1'b1;
		end else begin
			case (s_araddr[5:2])
				IDX_P1_DIR, IDX_P2_DIR, IDX_P3_DIR, IDX_P4_DIR: rdByte = 8'h00;
				IDX_P1_VAL: rdByte = p1Read;
				IDX_P2_VAL: rdByte = {mode_ff, p2Read};
				IDX_P3_VAL: rdByte = p3Read;
				IDX_P4_VAL: rdByte = p4Read;
				IDX_P3_CSR: rdByte = {strobeFlag_ff, irqEn_ff, 1'b0, srcSel_ff, latchEn_ff, 3'h0};
				default: rdBad = 1'b1;
			endcase
		end
	end

	// Read data flop; taken in the handshake cycle.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rData_ff <= 32'h0000_0000;
			rResp_ff <= RESP_OKAY;
		end else if (rdFire) begin
			rData_ff <= {24'h00_0000, rdByte};
			rResp_ff <= rdBad ? RESP_SLVERR : RESP_OKAY;
		end
	end

	// Side-effect strobes of register accesses.
	assign p3DataRead = rdFire && !rdBad && (s_araddr[5:2] == IDX_P3_VAL);
	assign p3DataWrite = wrLane && (awIdx_ff == IDX_P3_VAL);
	assign csrRead = rdFire && !rdBad && (s_araddr[5:2] == IDX_P3_CSR);
	assign strobeFall = single && strobePrev_ff && !strobeLineOneIn;

	// Direction and data registers written from the bus.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			p1Dir_ff <= DIR_RESET;
			p2Dir_ff <= DIR_RESET[4:0];
			p3Dir_ff <= DIR_RESET;
			p4Dir_ff <= DIR_RESET;
			p1Data_ff <= DATA_RESET;
			p2Data_ff <= DATA_RESET[4:0];
			p3Data_ff <= DATA_RESET;
			p4Data_ff <= DATA_RESET;
		end else if (wrLane) begin
			case (awIdx_ff)
				IDX_P1_DIR: p1Dir_ff <= wData_ff[7:0];
				IDX_P2_DIR: p2Dir_ff <= wData_ff[4:0];
				IDX_P3_DIR: p3Dir_ff <= wData_ff[7:0];
				IDX_P4_DIR: p4Dir_ff <= wData_ff[7:0];
				IDX_P1_VAL: p1Data_ff <= wData_ff[7:0];
				IDX_P2_VAL: p2Data_ff <= wData_ff[4:0];
				IDX_P3_VAL: p3Data_ff <= wData_ff[7:0];
				IDX_P4_VAL: p4Data_ff <= wData_ff[7:0];
				default: ;
			endcase
		end
	end

	// Mode code: reset cannot load a pin level, so it is taken on the first edge
	// after release. Mode 4 may move to 5 by a write of the switch bit.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= MODE_RESET;
			modeTaken_ff <= 1'b0;
		end else if (!modeTaken_ff) begin
			mode_ff <= port2In[2:0];
			modeTaken_ff <= 1'b1;
		end else if (wrLane && awIdx_ff == IDX_P2_VAL && mode_ff == MODE_SC_TEST &&
				wData_ff[P2_MODE_SWITCH_BIT]) begin
			mode_ff <= MODE_NMUX;
		end
	end

	// Strobe control fields; the flag bit itself is read-only.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			latchEn_ff <= 1'b0;
			srcSel_ff <= 1'b0;
			irqEn_ff <= 1'b0;
		end else if (wrLane && awIdx_ff == IDX_P3_CSR) begin
			latchEn_ff <= wData_ff[CSR_LATCH_BIT];
			srcSel_ff <= wData_ff[CSR_SRCSEL_BIT];
			irqEn_ff <= wData_ff[CSR_IEN_BIT];
		end
	end

	// Strobe flag: a status read with the flag up arms the clear, and the next
	// port three data access completes it. A new edge in that cycle wins.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			strobePrev_ff <= 1'b1;
			strobeFlag_ff <= 1'b0;
			clearArmed_ff <= 1'b0;
		end else begin
			strobePrev_ff <= strobeLineOneIn;
			if (strobeFall) begin
				strobeFlag_ff <= 1'b1;
			end else if (clearArmed_ff && (p3DataRead || p3DataWrite)) begin
				strobeFlag_ff <= 1'b0;
			end
			if (csrRead && strobeFlag_ff) begin
				clearArmed_ff <= 1'b1;
			end else if (p3DataRead || p3DataWrite) begin
				clearArmed_ff <= 1'b0;
			end
		end
	end

	// Input latch: held from a strobe fall until a port three data read.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			p3Latch_ff <= 8'h00;
			p3Held_ff <= 1'b0;
		end else if (p3DataRead) begin
			p3Held_ff <= 1'b0;
		end else if (strobeFall && latchEn_ff && !p3Held_ff) begin
			p3Latch_ff <= port3In;
			p3Held_ff <= 1'b1;
		end
	end

	// E divider: four mclk cycles per E cycle, high in the data half.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase_ff <= PH_ADDR;
			eClk_ff <= 1'b0;
		end else begin
			case (phase_ff)
				PH_ADDR: phase_ff <= PH_TURN;
				PH_TURN: phase_ff <= PH_DATA0;
				PH_DATA0: phase_ff <= PH_DATA1;
				PH_DATA1: phase_ff <= PH_ADDR;
				default: phase_ff <= PH_ADDR;
			endcase
			eClk_ff <= phase_ff[1];
		end
	end

	// Read data from an external cycle, caught at the end of E high.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			extRdata_ff <= 8'h00;
		end else if (!single && busReq.req && busReq.rw && phase_ff == PH_DATA1) begin
			extRdata_ff <= port3In;
		end
	end

	assign ioWin = busReq.req && (busReq.addr >= IO_WIN_LO) && (busReq.addr <= IO_WIN_HI);

	// Pin drives for ports one, two and four, registered so pins never glitch.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			p1Drive_ff <= '0;
			p2Out_ff <= 5'h00;
			p2Oe_ff <= 5'h00;
			p4Drive_ff <= '0;
		end else begin
			p1Drive_ff.out <= p1Data_ff;
			p1Drive_ff.oe <= p1Dir_ff;
			p2Out_ff <= {p2Data_ff[4:2], (p2Dir_ff[1] ? compareOut : p2Data_ff[1]),
				p2Data_ff[0]};
			p2Oe_ff <= p2Dir_ff;
			case (busType)
				BUS_SINGLE: begin
					p4Drive_ff.out <= p4Data_ff;
					p4Drive_ff.oe <= p4Dir_ff;
				end
				BUS_NMUX: begin
					p4Drive_ff.out <= busReq.addr[7:0];
					p4Drive_ff.oe <= p4Dir_ff;
				end
				default: begin
					// Upper address; in mode 6 only the lines chosen by direction.
					p4Drive_ff.out <= busReq.addr[15:8];
					p4Drive_ff.oe <= (mode_ff == MODE_MUX_PARTIAL) ? p4Dir_ff : 8'hFF;
				end
			endcase
		end
	end

	// Port three and the strobe lines follow the bus type and the E phase.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			p3Drive_ff <= '0;
			s1Out_ff <= 1'b1;
			s1Oe_ff <= 1'b0;
			s2_ff <= 1'b1;
		end else begin
			case (busType)
				BUS_SINGLE: begin
					p3Drive_ff.out <= p3Data_ff;
					p3Drive_ff.oe <= p3Dir_ff;
					s1Out_ff <= 1'b1;
					s1Oe_ff <= 1'b0;
					// One-cycle low pulse on the chosen kind of data access.
					s2_ff <= ~(srcSel_ff ? p3DataWrite : p3DataRead);
				end
				BUS_NMUX: begin
					p3Drive_ff.out <= busReq.wdata;
					p3Drive_ff.oe <= {8{busReq.req && !busReq.rw && phase_ff[1]}};
					s1Out_ff <= ~ioWin;
					s1Oe_ff <= 1'b1;
					s2_ff <= ~busReq.req | busReq.rw;
				end
				default: begin
					s1Oe_ff <= 1'b1;
					s2_ff <= ~busReq.req | busReq.rw;
					// Strobe high over the address phase, falling before turnaround.
					s1Out_ff <= busReq.req && (phase_ff == PH_ADDR);
					case (phase_ff)
						PH_ADDR: begin
							p3Drive_ff.out <= busReq.addr[7:0];
							p3Drive_ff.oe <= {8{busReq.req}};
						end
						PH_TURN: begin
							p3Drive_ff.out <= 8'h00;
							p3Drive_ff.oe <= 8'h00;
						end
						default: begin
							p3Drive_ff.out <= busReq.wdata;
							p3Drive_ff.oe <= {8{busReq.req && !busReq.rw}};
						end
					endcase
				end
			endcase
		end
	end

	// Interrupt line, active low, raised only while enabled and flagged.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irqN_ff <= 1'b1;
		end else begin
			irqN_ff <= ~(single && irqEn_ff && strobeFlag_ff);
		end
	end

	// Every output comes straight from its flop.
	assign s_awready = awReady_ff;
	assign s_wready = wReady_ff;
	assign s_bvalid = bValid_ff;
	assign s_bresp = bResp_ff;
	assign s_arready = arReady_ff;
	assign s_rvalid = rValid_ff;
	assign s_rdata = rData_ff;
	assign s_rresp = rResp_ff;
	assign extRdata = extRdata_ff;
	assign busClockE = eClk_ff;
	assign maskableIrqLineOneN = irqN_ff;
	assign port1Drive = p1Drive_ff;
	assign port2Out = p2Out_ff;
	assign port2Oe = p2Oe_ff;
	assign port3Drive = p3Drive_ff;
	assign port4Drive = p4Drive_ff;
	assign strobeLineOneOut = s1Out_ff;
	assign strobeLineOneOe = s1Oe_ff;
	assign strobeLineTwo = s2_ff;

endmodule : mpps_ports
